// File: rtl/readout_protect.v
// Purpose: hands finished results to read-out words with read protection
// Assumes: APB slave with zero wait states, results arrive as one-cycle pulses
// Notes: the freeze opens on an irq cause read and closes on a closing status read
`timescale 1ns/10ps
`include "readout_defs.vh"

module readout_protect #(
	parameter [31:0] PERIOD_CYCLES = `MEAS_PERIOD_CYC
) (
	// clock and reset
	input  wire                 CLK,
	input  wire                 RST_N,
	// apb slave
	input  wire                 PSEL,
	input  wire                 PENABLE,
	input  wire                 PWRITE,
	input  wire [7:0]           PADDR,
	input  wire [31:0]          PWDATA,
	output wire [31:0]          PRDATA,
	output wire                 PREADY,
	output wire                 PSLVERR,
	// measurement engine
	output wire                 MEAS_START,
	input  wire                 MEAS_DONE,
	input  wire [`WORD_W-1:0]   MEAS_IR,
	input  wire [`WORD_W-1:0]   MEAS_TEMP,
	// interrupts
	output wire                 IRQ,
	output wire                 IRQ_OUT_LOW_O,
	output wire                 IRQ_OUT_LOW_OE
);

	// register hit test, used by every access decode
	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	// control and interrupt registers
	reg  [2:0]          ctrl_r;
	reg  [2:0]          ctrl_nxt;
	reg  [`IRQ_W-1:0]   cause_r;
	reg  [`IRQ_W-1:0]   cause_nxt;
	reg  [`IRQ_W-1:0]   mask_r;
	reg  [`IRQ_W-1:0]   mask_nxt;
	reg                 shot_r;
	reg                 shot_nxt;

	// protection state
	reg                 fresh_r;
	reg                 fresh_nxt;
	reg                 overrun_r;
	reg                 overrun_nxt;
	reg                 freeze_r;
	reg                 freeze_nxt;
	reg                 pend_r;
	reg                 pend_nxt;
	reg  [`WORD_W-1:0]  buf_ir_r;
	reg  [`WORD_W-1:0]  buf_temp_r;

	// store load path
	reg                 load;
	reg  [`WORD_W-1:0]  load_ir;
	reg  [`WORD_W-1:0]  load_temp;
	wire [`WORD_W-1:0]  store_rd;

	// read data path
	reg  [31:0]         prdata_r;
	reg  [31:0]         prdata_nxt;
	reg                 sel_store_r;

	// bus decode
	wire setup   = PSEL & ~PENABLE;
	wire access  = PSEL & PENABLE;
	wire wr_acc  = access & PWRITE;
	wire rd_acc  = access & ~PWRITE;
	wire mapped  = hit(PADDR, `OFS_CTRL) | hit(PADDR, `OFS_FIRST_STAT) |
	               hit(PADDR, `OFS_IRQ_CAUSE) | hit(PADDR, `OFS_IRQ_MASK) |
	               hit(PADDR, `OFS_IR_DATA) | hit(PADDR, `OFS_TEMP_DATA) |
	               hit(PADDR, `OFS_CLOSE_STAT);
	wire rd_cause = rd_acc & hit(PADDR, `OFS_IRQ_CAUSE);
	wire rd_close = rd_acc & hit(PADDR, `OFS_CLOSE_STAT);
	wire is_data  = hit(PADDR, `OFS_IR_DATA) | hit(PADDR, `OFS_TEMP_DATA);

	// zero wait states keep the master's handshake trivial
	assign PREADY  = 1'b1;
	assign PSLVERR = access & ~mapped;
	assign PRDATA  = sel_store_r ? {16'h0000, store_rd} : prdata_r;

	// read-out words sit in their own store
	result_store u_store (
		.clk     (CLK),
		.rst_n   (RST_N),
		.we      (load),
		.wd_ir   (load_ir),
		.wd_temp (load_temp),
		.rd_idx  (hit(PADDR, `OFS_TEMP_DATA)),
		.rd_data (store_rd)
	);

	// start pacing
	meas_timer #(
		.PERIOD_CYCLES (PERIOD_CYCLES)
	) u_timer (
		.clk         (CLK),
		.rst_n       (RST_N),
		.cont_en     (ctrl_r[`CTRL_CONT]),
		.shot        (shot_r),
		.start_pulse (MEAS_START)
	);

	// protection state: reads first, then completions, so a result
	// arriving in the clearing cycle never gets lost
	always @* begin
		freeze_nxt  = freeze_r;
		fresh_nxt   = fresh_r;
		overrun_nxt = overrun_r;
		pend_nxt    = pend_r;
		load        = 1'b0;
		load_ir     = buf_ir_r;
		load_temp   = buf_temp_r;
		// closing read ends the freeze and clears the flags
		if (rd_close) begin
			freeze_nxt  = 1'b0;
			fresh_nxt   = 1'b0;
			overrun_nxt = 1'b0;
			if (pend_r) begin
				load      = 1'b1;
				fresh_nxt = 1'b1;
				pend_nxt  = 1'b0;
			end
		end
		// opening read copies the latest result and freezes
		if (rd_cause && !freeze_r) begin
			freeze_nxt = 1'b1;
			if (pend_r) begin
				load     = 1'b1;
				pend_nxt = 1'b0;
			end
		end
		// a completion goes to the buffer; the store only follows when open
		if (MEAS_DONE) begin
			if (freeze_nxt) begin
				if (pend_nxt)
					overrun_nxt = 1'b1;
				pend_nxt = 1'b1;
			end else begin
				if (fresh_nxt)
					overrun_nxt = 1'b1;
				fresh_nxt = 1'b1;
				load      = 1'b1;
				load_ir   = MEAS_IR;
				load_temp = MEAS_TEMP;
			end
		end
	end

	// buffer always holds the newest result; store holds the old one meanwhile
	always @(posedge CLK) begin
		if (!RST_N) begin
			buf_ir_r   <= {`WORD_W{1'b0}};
			buf_temp_r <= {`WORD_W{1'b0}};
		end else if (MEAS_DONE) begin
			buf_ir_r   <= MEAS_IR;
			buf_temp_r <= MEAS_TEMP;
		end
	end

	// control, cause and mask updates
	always @* begin
		ctrl_nxt  = ctrl_r;
		mask_nxt  = mask_r;
		shot_nxt  = 1'b0;
		cause_nxt = cause_r;
		if (wr_acc && hit(PADDR, `OFS_CTRL)) begin
			ctrl_nxt = {PWDATA[`CTRL_IRQ_EN], 1'b0, PWDATA[`CTRL_CONT]};
			shot_nxt = PWDATA[`CTRL_SHOT];
		end
		if (wr_acc && hit(PADDR, `OFS_IRQ_MASK))
			mask_nxt = PWDATA[`IRQ_W-1:0];
		// reading the cause releases the pin; a write of one clears a bit
		if (rd_cause)
			cause_nxt = {`IRQ_W{1'b0}};
		else if (wr_acc && hit(PADDR, `OFS_IRQ_CAUSE))
			cause_nxt = cause_r & ~PWDATA[`IRQ_W-1:0];
		// new events win over the clear in the same cycle
		if (fresh_nxt && !fresh_r && ctrl_r[`CTRL_IRQ_EN])
			cause_nxt[`IRQ_FRESH_RESULT_FLAG] = 1'b1;
		if (overrun_nxt && !overrun_r)
			cause_nxt[`IRQ_OVR] = 1'b1;
	end

	// read data snapshot taken in the setup cycle
	always @* begin
		prdata_nxt = 32'h00000000;
		if (hit(PADDR, `OFS_CTRL))
			prdata_nxt[2:0] = ctrl_r;
		else if (hit(PADDR, `OFS_FIRST_STAT))
			prdata_nxt[2:0] = {pend_r, freeze_r, fresh_r};
		else if (hit(PADDR, `OFS_IRQ_CAUSE))
			prdata_nxt[`IRQ_W-1:0] = cause_r;
		else if (hit(PADDR, `OFS_IRQ_MASK))
			prdata_nxt[`IRQ_W-1:0] = mask_r;
		else if (hit(PADDR, `OFS_CLOSE_STAT))
			prdata_nxt[0] = overrun_r;
	end

	// state registers
	always @(posedge CLK) begin
		if (!RST_N) begin
			ctrl_r      <= `CTRL_RST;
			mask_r      <= `IRQ_MASK_RST;
			cause_r     <= {`IRQ_W{1'b0}};
			shot_r      <= 1'b0;
			fresh_r     <= 1'b0;
			overrun_r   <= 1'b0;
			freeze_r    <= 1'b0;
			pend_r      <= 1'b0;
			prdata_r    <= 32'h00000000;
			sel_store_r <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			mask_r    <= mask_nxt;
			cause_r   <= cause_nxt;
			shot_r    <= shot_nxt;
			fresh_r   <= fresh_nxt;
			overrun_r <= overrun_nxt;
			freeze_r  <= freeze_nxt;
			pend_r    <= pend_nxt;
			if (setup) begin
				prdata_r    <= PWRITE ? 32'h00000000 : prdata_nxt;
				sel_store_r <= ~PWRITE & is_data;
			end
		end
	end

	// open-drain pin: pulled low while an unmasked cause is set
	assign IRQ            = |(cause_r & mask_r);
	assign IRQ_OUT_LOW_O  = 1'b0;
	assign IRQ_OUT_LOW_OE = IRQ;

endmodule

// File: rtl/readout_defs.vh
// Purpose: constants for the measurement read-out protection block
// Assumes: APB register access, 32-bit data, one clock at 250 MHz
// Notes: all offsets are byte addresses of aligned words
`ifndef READOUT_DEFS_VH
`define READOUT_DEFS_VH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_FIRST_STAT  8'h04
`define OFS_IRQ_CAUSE   8'h08
`define OFS_IRQ_MASK    8'h0C
`define OFS_IR_DATA     8'h10
`define OFS_TEMP_DATA   8'h14
`define OFS_CLOSE_STAT  8'h18

// control fields
`define CTRL_CONT       0
`define CTRL_SHOT       1
`define CTRL_IRQ_EN     2

// irq cause and mask fields, reset values
`define IRQ_FRESH_RESULT_FLAG        0
`define IRQ_OVR         1
`define IRQ_W           2
`define IRQ_MASK_RST    2'h3
`define CTRL_RST        3'h0

// result words
`define WORD_W          16
`define WORD_DEPTH      2

// timing
`define MEAS_PERIOD_MS  100
`define CLK_FREQ_MHZ    250
`define MEAS_PERIOD_CYC (`MEAS_PERIOD_MS * 1000 * `CLK_FREQ_MHZ)

`endif

// File: rtl/result_store.v
// Purpose: read-out word store, loaded as a whole, read one word at a time
// Assumes: synchronous active-low reset
// Notes: read data come from a register, one cycle after the index
`timescale 1ns/10ps
`include "readout_defs.vh"

module result_store (
	// clock and reset
	input  wire                 clk,
	input  wire                 rst_n,
	// parallel load
	input  wire                 we,
	input  wire [`WORD_W-1:0]   wd_ir,
	input  wire [`WORD_W-1:0]   wd_temp,
	// read port
	input  wire                 rd_idx,
	output reg  [`WORD_W-1:0]   rd_data
);

	reg  [`WORD_W-1:0] mem [0:`WORD_DEPTH-1];
	wire [`WORD_W-1:0] wd  [0:`WORD_DEPTH-1];

	assign wd[0] = wd_ir;
	assign wd[1] = wd_temp;

	// every word loads together so ir and temperature always pair up
	genvar i;
	generate
		for (i = 0; i < `WORD_DEPTH; i = i + 1) begin : g_word
			always @(posedge clk) begin
				if (!rst_n)
					mem[i] <= {`WORD_W{1'b0}};
				else if (we)
					mem[i] <= wd[i];
			end
		end
	endgenerate

	// registered read
	always @(posedge clk) begin
		if (!rst_n)
			rd_data <= {`WORD_W{1'b0}};
		else
			rd_data <= mem[rd_idx];
	end

endmodule

// File: rtl/meas_timer.v
// Purpose: measurement start pacing for continuous and single-shot use
// Assumes: one start pulse is one measurement request
// Notes: first continuous start comes right after enabling
`timescale 1ns/10ps
`include "readout_defs.vh"

module meas_timer #(
	parameter [31:0] PERIOD_CYCLES = `MEAS_PERIOD_CYC
) (
	// clock and reset
	input  wire clk,
	input  wire rst_n,
	// mode
	input  wire cont_en,
	input  wire shot,
	// request
	output reg  start_pulse
);

	reg [31:0] count_r;
	reg        run_r;

	// period counter restarts whenever continuous mode is entered
	always @(posedge clk) begin
		if (!rst_n) begin
			count_r     <= 32'h00000000;
			run_r       <= 1'b0;
			start_pulse <= 1'b0;
		end else begin
			run_r <= cont_en;
			if (cont_en && (!run_r || count_r == PERIOD_CYCLES - 32'h00000001)) begin
				count_r     <= 32'h00000000;
				start_pulse <= 1'b1;
			end else begin
				count_r     <= cont_en ? count_r + 32'h00000001 : 32'h00000000;
				start_pulse <= shot;
			end
		end
	end

endmodule

// File: bench/readout_sva.sv
// Purpose: port checker for the read-out protection block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module readout_sva (
	// clock and reset
	input wire logic        CLK,
	input wire logic        RST_N,
	// apb
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// engine and interrupt
	input wire logic        MEAS_START,
	input wire logic        MEAS_DONE,
	input wire logic [15:0] MEAS_IR,
	input wire logic [15:0] MEAS_TEMP,
	input wire logic        IRQ,
	input wire logic        IRQ_OUT_LOW_O,
	input wire logic        IRQ_OUT_LOW_OE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// access phase of any transfer
	wire acc = PSEL && PENABLE;
	a_pin_follows: assert property (IRQ_OUT_LOW_OE == IRQ && !IRQ_OUT_LOW_O)
		else $error("pin drive differs from irq");
	a_cause_release: assert property (acc && !PWRITE && PADDR == 8'h08 && !MEAS_DONE |=> !IRQ_OUT_LOW_OE)
		else $error("pin not released after cause read");
	a_irq_cause: assert property ($rose(IRQ) |-> $past(MEAS_DONE) || $past(acc))
		else $error("irq rose with no event");
	a_unmapped_err: assert property (acc && PADDR > 8'h18 |-> PSLVERR && PRDATA == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc && PADDR <= 8'h18 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
		else $error("mapped access refused");
	a_err_access: assert property (PSLVERR |-> acc)
		else $error("error outside access");
	a_start_pulse: assert property (MEAS_START |=> !MEAS_START)
		else $error("start wider than one cycle");
	a_shot_start: assert property (acc && PWRITE && PADDR == 8'h00 && PWDATA[1] |-> ##[1:2] MEAS_START)
		else $error("no start after shot write");
	c_cause_read: cover property (acc && !PWRITE && PADDR == 8'h08);
	c_close_read: cover property (acc && !PWRITE && PADDR == 8'h18);
	c_done_irq: cover property (MEAS_DONE ##1 IRQ);
endmodule
bind readout_protect readout_sva readout_sva_i (.*);

// File: bench/meas_engine.sv
// Purpose: behavioural measurement engine facing the read-out block
// Assumes: one result per start request, fixed latency
// Notes: result lines carry no stale copy outside the done pulse
`timescale 1ns/10ps
module meas_engine #(
	parameter int LAT = 3
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// request and preset result
	input  wire logic        start,
	input  wire logic [15:0] val,
	// result
	output logic             done,
	output logic [15:0]      ir,
	output logic [15:0]      temp
);
	logic [3:0]  cnt;
	logic [15:0] v;
	// count down from the start request, then pulse done for one cycle
	always @(posedge clk) begin
		if (!rst_n) begin
			cnt  <= 4'h0;
			done <= 1'b0;
		end else begin
			done <= (cnt == 4'h1);
			if (start) begin
				cnt <= 4'(LAT);
				v   <= val;
			end else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
	// off the pulse the lines show the inverse, so a late sample cannot pass
	assign ir   = done ? v : ~v;
	assign temp = done ? v ^ 16'hA5A5 : ~v;
endmodule

// File: bench/tb.sv
// Purpose: self-checking bench for the read-out protection block
// Assumes: short measurement period, engine latency of a few cycles
// Notes: reads queue their expectation, a monitor compares at the access edge
`timescale 1ns/10ps
module tb;
	logic        CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic        PREADY, PSLVERR, MEAS_START, MEAS_DONE, IRQ, OLO, OLE;
	logic [15:0] MEAS_IR, MEAS_TEMP, v1, v2, v3, val = 16'h0;
	logic [32:0] expq[$], mq[$];
	int          fails = 0, total_checks = 0, cyc = 0;
	localparam logic [32:0] W = 33'h1FFFFFFFF, B0 = 33'h100000001, B01 = 33'h100000003, N = 33'h100000000;
	readout_protect #(.PERIOD_CYCLES(20)) readout_protect_i (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .MEAS_START(MEAS_START), .MEAS_DONE(MEAS_DONE), .MEAS_IR(MEAS_IR),
		.MEAS_TEMP(MEAS_TEMP), .IRQ(IRQ), .IRQ_OUT_LOW_O(OLO), .IRQ_OUT_LOW_OE(OLE));
	meas_engine meas_engine_i (.clk(CLK), .rst_n(RST_N), .start(MEAS_START), .val(val), .done(MEAS_DONE),
		.ir(MEAS_IR), .temp(MEAS_TEMP));
	initial forever #2 CLK = ~CLK;
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
		@(posedge CLK);
		PENABLE <= 1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		{PSEL, PENABLE} <= 2'b00;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
		expq.push_back(e & m);
		mq.push_back(m);
		apb(0, a, 0);
	endtask
	// request one shot with a random result and wait for its completion
	task automatic meas(output logic [15:0] v);
		int k;
		v = 16'($urandom);
		val <= v;
		apb(1, 8'h00, 32'h6);
		k = 0;
		while (MEAS_DONE !== 1'b1 && k < 20) begin
			@(posedge CLK);
			k++;
		end
		@(posedge CLK);
	endtask
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// monitor: oldest note against each completed read
	always @(posedge CLK) begin
		cyc++;
		if (PSEL && PENABLE && PREADY && !PWRITE && mq.size() > 0)
			chk({PSLVERR, PRDATA} & mq.pop_front(), expq.pop_front());
		if (cyc == 4000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(5881));
		repeat (10) @(posedge CLK);
		RST_N <= 1;
		rd(8'h04, 0, 33'h100000007);
		rd(8'h0C, 3, W);
		rd(8'h40, N, W);
		$display("test reset done");
		apb(1, 8'h0C, 0);
		meas(v1);
		chk({32'h0, IRQ}, 0);
		apb(1, 8'h0C, 3);
		@(posedge CLK);
		chk({32'h0, OLE}, 1);
		rd(8'h04, 1, B0);
		rd(8'h08, 1, B01);
		@(posedge CLK);
		chk({32'h0, OLE}, 0);
		rd(8'h10, {17'h0, v1}, W);
		rd(8'h14, {17'h0, v1 ^ 16'hA5A5}, W);
		rd(8'h18, 0, B0);
		rd(8'h04, 0, B0);
		$display("test normal done");
		meas(v1);
		meas(v2);
		rd(8'h04, 1, B0);
		rd(8'h08, 3, B01);
		rd(8'h10, {17'h0, v2}, W);
		rd(8'h18, 1, B0);
		rd(8'h04, 0, B0);
		$display("test skip done");
		meas(v1);
		rd(8'h08, 0, N);
		meas(v2);
		rd(8'h10, {17'h0, v1}, W);
		rd(8'h18, 0, B0);
		rd(8'h10, {17'h0, v2}, W);
		rd(8'h04, 1, B0);
		rd(8'h08, 0, N);
		rd(8'h18, 0, N);
		$display("test one during freeze done");
		meas(v1);
		rd(8'h08, 0, N);
		meas(v2);
		meas(v3);
		rd(8'h10, {17'h0, v1}, W);
		rd(8'h18, 1, B0);
		rd(8'h08, 0, N);
		rd(8'h10, {17'h0, v3}, W);
		rd(8'h18, 0, B0);
		$display("test two during freeze done");
		v1 = 16'($urandom);
		val <= v1;
		apb(1, 8'h00, 1);
		repeat (30) @(posedge CLK);
		apb(1, 8'h00, 0);
		rd(8'h04, 1, B0);
		rd(8'h08, 0, N);
		rd(8'h10, {17'h0, v1}, W);
		rd(8'h18, 0, N);
		$display("test continuous done");
		wrap_up();
	end
endmodule
